// [pofld_defines.svh]
/*
  Register offsets, field positions, reset values for the synthesizer control.
  Assumes byte-wide registers; multi-byte words put their top bits at the
  lowest offset.
*/
`ifndef POFLD_DEFINES_SVH
`define POFLD_DEFINES_SVH
`define POFLD_A_FRAC_H 8'h01
`define POFLD_A_FRAC_M 8'h02
`define POFLD_A_FRAC_L 8'h03
`define POFLD_A_DEN_H 8'h04
`define POFLD_A_DEN_M 8'h05
`define POFLD_A_DEN_L 8'h06
`define POFLD_A_INT_H 8'h07
`define POFLD_A_INT_L 8'h08
`define POFLD_A_PUMP_N 8'h0A
`define POFLD_A_PUMP_F 8'h0B
`define POFLD_A_CTRL 8'h0C
`define POFLD_A_FTIME_H 8'h0D
`define POFLD_A_FTIME_L 8'h0E
`define POFLD_A_OFSA_H 8'h0F
`define POFLD_A_OFSA_M 8'h10
`define POFLD_A_OFSA_L 8'h11
`define POFLD_A_OFSSEL 8'h28
`define POFLD_A_OFSB_H 8'h29
`define POFLD_A_OFSB_M 8'h2A
`define POFLD_A_OFSB_L 8'h2B
`define POFLD_A_LOCKCNT 8'h3F
`define POFLD_A_UNLKCNT 8'h40
`define POFLD_A_IRQSTAT 8'h50
`define POFLD_A_IRQMASK 8'h51
`define POFLD_A_STATUS 8'h52
`define POFLD_B_DSM_EN 0
`define POFLD_B_FAST_EN 1
`define POFLD_B_LD_OFF 2
`define POFLD_I_LOCK 0
`define POFLD_I_UNLOCK 1
`define POFLD_I_FASTDONE 2
`define POFLD_RST_CNT 8'h01
`define POFLD_REF_DIV 50
`endif

// [pofld_pkg.sv]
/*
  Types shared by the synthesizer control modules.
  Assumes nothing beyond the defines header.
*/
package pofld_pkg;
  typedef enum logic {POFLD_UNLOCKED, POFLD_LOCKED} pofld_ld_e;
  typedef logic [17:0] pofld_word_t;
  typedef logic [11:0] pofld_int_t;
endpackage

// [pofld_tick_div.sv]
/*
  Divider giving a one-cycle phase-detector reference enable.
  Assumes clk_sys is the only clock; DIV is at least 2.
*/
`timescale 1ns/1ps
module pofld_tick_div #(
  parameter int DIV = 50
) (
  input wire logic clk_sys,
  input wire logic reset,
  output logic tick
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == 16'(DIV - 1));
      if (cnt_q == 16'(DIV - 1)) begin
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule

// [pofld_frac_calc.sv]
/*
  Offset arithmetic: effective numerator and integer divide value.
  Assumes numerator below denominator; pure combinational.
*/
`timescale 1ns/1ps
module pofld_frac_calc (
  input wire pofld_pkg::pofld_word_t fracNum,
  input wire pofld_pkg::pofld_word_t fracDen,
  input wire pofld_pkg::pofld_int_t intDiv,
  input wire pofld_pkg::pofld_word_t offsetWord,
  output pofld_pkg::pofld_word_t effFrac,
  output pofld_pkg::pofld_int_t effInt,
  output logic carry,
  output logic borrow
);
  logic signed [19:0] sum;
  logic signed [19:0] den;
  always_comb begin
    // offset is signed, numerator and denominator unsigned
    sum = $signed({2'b00, fracNum}) + $signed({{2{offsetWord[17]}}, offsetWord});
    den = $signed({2'b00, fracDen});
    carry = 1'b0;
    borrow = 1'b0;
    effFrac = sum[17:0];
    effInt = intDiv;
    if (sum < 20'sh00000) begin
      borrow = 1'b1;
      effFrac = 18'(sum + den);
      effInt = intDiv - 12'h001;
    end else if (sum >= den) begin
      carry = 1'b1;
      effFrac = 18'(sum - den);
      effInt = intDiv + 12'h001;
    end
  end
endmodule

// [pofld_top.sv]
/*
  Synthesizer digital control: frequency offset, fast lock timer, lock detect.
  Assumes a byte register port on clk_sys; pins and phase error flags are
  asynchronous and are synchronised here.
*/
// Operation
// - word A low byte write recomputes, commits upper
// - switch B to A recomputes
// - under B 0x11 and 0x08 recompute, not 0x2B
// - switch A to B recomputes
// - offsets signed, numerator denominator unsigned
// - overflow subtracts denominator, integer plus one
// - negative adds denominator, integer minus one
// - fast enable plus 0x08 write starts timer
// - timer running: switch closed, fast pump code
// - timer length is field times reference period
// - five-bit pump code, current code plus one
// - lock detect active while control bit clear
// - after reset lock pin low, unlocked
// - N good comparisons in a row lock
// - N bad comparisons in a row unlock
// - word B only when select set, pin low
`timescale 1ns/1ps
`include "pofld_defines.svh"
module pofld_top #(
  parameter int REF_DIV = `POFLD_REF_DIV,
  parameter int CNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic transmitPowerdownPin,
  input wire logic phaseErrBelowRef,
  input wire logic phaseErrAboveT,
  output pofld_pkg::pofld_int_t divIntEff,
  output pofld_pkg::pofld_word_t fracNumEff,
  output pofld_pkg::pofld_word_t fracDenominator,
  output logic sigmaDeltaEnable,
  output logic loopSwitchClosed,
  output logic [4:0] pumpCurrentCode,
  output logic [5:0] pumpCurrentSteps,
  output logic lockPin,
  output logic irq
);
////////////////////////////////////////////////////////////////////////////////
  pofld_pkg::pofld_word_t fracNum_q, fracDen_q, ofsA_q, ofsB_q;
  pofld_pkg::pofld_int_t intDiv_q;
  logic [4:0] normalPumpCode_q, fastPumpCode_q;
  logic [2:0] ctrl_q, irqStatus_q, irqMask_q, irqEvent;
  logic [12:0] fastTime_q;
  logic [9:0] ofsAStage_q;
  logic offsetSelect_q, wr;
  logic [CNT_W-1:0] lockTarget_q, unlockTarget_q;
  always_comb wr = regWrEn;
////////////////////////////////////////////////////////////////////////////////
  // configuration writes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fracNum_q <= 18'h00000;
      fracDen_q <= 18'h00000;
      intDiv_q <= 12'h000;
      normalPumpCode_q <= 5'h00;
      fastPumpCode_q <= 5'h00;
      ctrl_q <= 3'h0;
      fastTime_q <= 13'h0000;
      ofsAStage_q <= 10'h000;
      ofsA_q <= 18'h00000;
      ofsB_q <= 18'h00000;
      offsetSelect_q <= 1'b0;
      lockTarget_q <= CNT_W'(`POFLD_RST_CNT);
      unlockTarget_q <= CNT_W'(`POFLD_RST_CNT);
      irqMask_q <= 3'h0;
    end else if (wr) begin
      case (regAddr)
        `POFLD_A_FRAC_H: fracNum_q[17:16] <= regWrData[1:0];
        `POFLD_A_FRAC_M: fracNum_q[15:8] <= regWrData;
        `POFLD_A_FRAC_L: fracNum_q[7:0] <= regWrData;
        `POFLD_A_DEN_H: fracDen_q[17:16] <= regWrData[1:0];
        `POFLD_A_DEN_M: fracDen_q[15:8] <= regWrData;
        `POFLD_A_DEN_L: fracDen_q[7:0] <= regWrData;
        `POFLD_A_INT_H: intDiv_q[11:8] <= regWrData[3:0];
        `POFLD_A_INT_L: intDiv_q[7:0] <= regWrData;
        `POFLD_A_PUMP_N: normalPumpCode_q <= regWrData[4:0];
        `POFLD_A_PUMP_F: fastPumpCode_q <= regWrData[4:0];
        `POFLD_A_CTRL: ctrl_q <= regWrData[2:0];
        `POFLD_A_FTIME_H: fastTime_q[12:8] <= regWrData[4:0];
        `POFLD_A_FTIME_L: fastTime_q[7:0] <= regWrData;
        `POFLD_A_OFSA_H: ofsAStage_q[9:8] <= regWrData[1:0];
        `POFLD_A_OFSA_M: ofsAStage_q[7:0] <= regWrData;
        `POFLD_A_OFSA_L: ofsA_q <= {ofsAStage_q, regWrData};
        `POFLD_A_OFSSEL: offsetSelect_q <= regWrData[0];
        `POFLD_A_OFSB_H: ofsB_q[17:16] <= regWrData[1:0];
        `POFLD_A_OFSB_M: ofsB_q[15:8] <= regWrData;
        `POFLD_A_OFSB_L: ofsB_q[7:0] <= regWrData;
        `POFLD_A_LOCKCNT: lockTarget_q <= regWrData[CNT_W-1:0];
        `POFLD_A_UNLKCNT: unlockTarget_q <= regWrData[CNT_W-1:0];
        `POFLD_A_IRQMASK: irqMask_q <= regWrData[2:0];
        default: ;
      endcase
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] pdnSync_q, belowSync_q, aboveSync_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pdnSync_q <= 2'b00;
      belowSync_q <= 2'b00;
      aboveSync_q <= 2'b00;
    end else begin
      pdnSync_q <= {pdnSync_q[0], transmitPowerdownPin};
      belowSync_q <= {belowSync_q[0], phaseErrBelowRef};
      aboveSync_q <= {aboveSync_q[0], phaseErrAboveT};
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // offset selection and recompute
  logic selB, selB_q, selChange, wrOfsLow, wrIntLow, recalc, calcCarry, calcBorrow;
  pofld_pkg::pofld_word_t activeOfs, calcFrac;
  pofld_pkg::pofld_int_t intNext, calcInt;
  always_comb begin
    selB = offsetSelect_q & ~pdnSync_q[1];
    selChange = selB ^ selB_q;
    wrOfsLow = wr && (regAddr == `POFLD_A_OFSA_L);
    wrIntLow = wr && (regAddr == `POFLD_A_INT_L);
    recalc = wrOfsLow | selChange | wrIntLow;
    activeOfs = selB ? ofsB_q : (wrOfsLow ? {ofsAStage_q, regWrData} : ofsA_q);
    intNext = wrIntLow ? {intDiv_q[11:8], regWrData} : intDiv_q;
  end
  pofld_frac_calc pofld_frac_calc_inst (
    .fracNum(fracNum_q), .fracDen(fracDen_q), .intDiv(intNext), .offsetWord(activeOfs),
    .effFrac(calcFrac), .effInt(calcInt), .carry(calcCarry), .borrow(calcBorrow)
  );
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      selB_q <= 1'b0;
      divIntEff <= 12'h000;
      fracNumEff <= 18'h00000;
    end else begin
      selB_q <= selB;
      if (recalc) begin
        divIntEff <= calcInt;
        fracNumEff <= calcFrac;
      end
    end
  end
  always_comb begin
    fracDenominator = fracDen_q;
    sigmaDeltaEnable = ctrl_q[`POFLD_B_DSM_EN];
  end
////////////////////////////////////////////////////////////////////////////////
  // fast lock timer
  logic pfdTick, fastStart;
  logic [12:0] fastCnt_q, fastCnt_d;
  pofld_tick_div #(.DIV(REF_DIV)) pofld_tick_div_inst (
    .clk_sys(clk_sys), .reset(reset), .tick(pfdTick)
  );
  always_comb begin
    fastStart = wrIntLow && ctrl_q[`POFLD_B_FAST_EN];
    fastCnt_d = fastCnt_q;
    if (fastStart) begin
      fastCnt_d = fastTime_q;
    end else if (pfdTick && (fastCnt_q != 13'h0000)) begin
      fastCnt_d = fastCnt_q - 13'h0001;
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fastCnt_q <= 13'h0000;
      loopSwitchClosed <= 1'b0;
      pumpCurrentCode <= 5'h00;
      pumpCurrentSteps <= 6'h01;
    end else begin
      fastCnt_q <= fastCnt_d;
      loopSwitchClosed <= (fastCnt_d != 13'h0000);
      if (fastCnt_d != 13'h0000) begin
        pumpCurrentCode <= fastPumpCode_q;
        pumpCurrentSteps <= {1'b0, fastPumpCode_q} + 6'h01;
      end else begin
        pumpCurrentCode <= normalPumpCode_q;
        pumpCurrentSteps <= {1'b0, normalPumpCode_q} + 6'h01;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // digital lock detector
  pofld_pkg::pofld_ld_e ldState_q;
  logic [CNT_W-1:0] ldCnt_q;
  logic ldOff;
  always_comb ldOff = ctrl_q[`POFLD_B_LD_OFF];
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ldState_q <= pofld_pkg::POFLD_UNLOCKED;
      ldCnt_q <= '0;
    end else if (ldOff) begin
      ldState_q <= pofld_pkg::POFLD_UNLOCKED;
      ldCnt_q <= '0;
    end else if (pfdTick) begin
      case (ldState_q)
        pofld_pkg::POFLD_UNLOCKED: begin
          if (!belowSync_q[1]) begin
            ldCnt_q <= '0;
          end else if (ldCnt_q + CNT_W'(1) >= lockTarget_q) begin
            ldState_q <= pofld_pkg::POFLD_LOCKED;
            ldCnt_q <= '0;
          end else begin
            ldCnt_q <= ldCnt_q + CNT_W'(1);
          end
        end
        pofld_pkg::POFLD_LOCKED: begin
          if (!aboveSync_q[1]) begin
            ldCnt_q <= '0;
          end else if (ldCnt_q + CNT_W'(1) >= unlockTarget_q) begin
            ldState_q <= pofld_pkg::POFLD_UNLOCKED;
            ldCnt_q <= '0;
          end else begin
            ldCnt_q <= ldCnt_q + CNT_W'(1);
          end
        end
        default: begin
          ldState_q <= pofld_pkg::POFLD_UNLOCKED;
          ldCnt_q <= '0;
        end
      endcase
    end
  end
  always_comb lockPin = (ldState_q == pofld_pkg::POFLD_LOCKED);
////////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins
  logic ldLocked_q, fastBusy_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ldLocked_q <= 1'b0;
      fastBusy_q <= 1'b0;
    end else begin
      ldLocked_q <= lockPin;
      fastBusy_q <= (fastCnt_q != 13'h0000);
    end
  end
  always_comb begin
    irqEvent = 3'h0;
    irqEvent[`POFLD_I_LOCK] = lockPin & ~ldLocked_q;
    irqEvent[`POFLD_I_UNLOCK] = ~lockPin & ldLocked_q;
    irqEvent[`POFLD_I_FASTDONE] = fastBusy_q & (fastCnt_q == 13'h0000);
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irqStatus_q <= 3'h0;
    end else if (wr && (regAddr == `POFLD_A_IRQSTAT)) begin
      irqStatus_q <= (irqStatus_q & ~regWrData[2:0]) | irqEvent;
    end else begin
      irqStatus_q <= irqStatus_q | irqEvent;
    end
  end
  always_comb irq = |(irqStatus_q & irqMask_q);
////////////////////////////////////////////////////////////////////////////////
  // read back, data one cycle after the strobe
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      `POFLD_A_FRAC_H: rdMux = {6'h00, fracNum_q[17:16]};
      `POFLD_A_FRAC_M: rdMux = fracNum_q[15:8];
      `POFLD_A_FRAC_L: rdMux = fracNum_q[7:0];
      `POFLD_A_DEN_H: rdMux = {6'h00, fracDen_q[17:16]};
      `POFLD_A_DEN_M: rdMux = fracDen_q[15:8];
      `POFLD_A_DEN_L: rdMux = fracDen_q[7:0];
      `POFLD_A_INT_H: rdMux = {4'h0, intDiv_q[11:8]};
      `POFLD_A_INT_L: rdMux = intDiv_q[7:0];
      `POFLD_A_PUMP_N: rdMux = {3'h0, normalPumpCode_q};
      `POFLD_A_PUMP_F: rdMux = {3'h0, fastPumpCode_q};
      `POFLD_A_CTRL: rdMux = {5'h00, ctrl_q};
      `POFLD_A_FTIME_H: rdMux = {3'h0, fastTime_q[12:8]};
      `POFLD_A_FTIME_L: rdMux = fastTime_q[7:0];
      `POFLD_A_OFSA_H: rdMux = {6'h00, ofsA_q[17:16]};
      `POFLD_A_OFSA_M: rdMux = ofsA_q[15:8];
      `POFLD_A_OFSA_L: rdMux = ofsA_q[7:0];
      `POFLD_A_OFSSEL: rdMux = {7'h00, offsetSelect_q};
      `POFLD_A_OFSB_H: rdMux = {6'h00, ofsB_q[17:16]};
      `POFLD_A_OFSB_M: rdMux = ofsB_q[15:8];
      `POFLD_A_OFSB_L: rdMux = ofsB_q[7:0];
      `POFLD_A_LOCKCNT: rdMux = 8'(lockTarget_q);
      `POFLD_A_UNLKCNT: rdMux = 8'(unlockTarget_q);
      `POFLD_A_IRQSTAT: rdMux = {5'h00, irqStatus_q};
      `POFLD_A_IRQMASK: rdMux = {5'h00, irqMask_q};
      `POFLD_A_STATUS: rdMux = {5'h00, selB, loopSwitchClosed, lockPin};
      default: rdMux = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // checks
  chk_ofsa_commit: assert property (@(posedge clk_sys) disable iff (reset)
    (wrOfsLow && !selB) |=> (ofsA_q == $past({ofsAStage_q, regWrData}))
      && (fracNumEff == $past(calcFrac)))
    else $error("offset A low byte did not commit");
  chk_ofsa_upper_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (wr && (regAddr == `POFLD_A_OFSA_H)) |=> $stable(ofsA_q))
    else $error("offset A upper byte acted early");
  chk_switch_to_a: assert property (@(posedge clk_sys) disable iff (reset)
    (selB_q && !selB) |=> (fracNumEff == $past(calcFrac)) && (divIntEff == $past(calcInt)))
    else $error("no recompute on switch to A");
  chk_b_low_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    (wr && (regAddr == `POFLD_A_OFSB_L) && !selChange) |=> $stable(fracNumEff)
      && $stable(divIntEff))
    else $error("offset B low byte recomputed");
  chk_switch_to_b: assert property (@(posedge clk_sys) disable iff (reset)
    (!selB_q && selB) |=> (fracNumEff == $past(calcFrac)))
    else $error("no recompute on switch to B");
  chk_carry_int: assert property (@(posedge clk_sys) disable iff (reset)
    (recalc && calcCarry) |=> (divIntEff == $past(intNext) + 12'h001))
    else $error("carry did not raise integer");
  chk_borrow_int: assert property (@(posedge clk_sys) disable iff (reset)
    (recalc && calcBorrow) |=> (divIntEff == $past(intNext) - 12'h001))
    else $error("borrow did not lower integer");
  chk_fast_start: assert property (@(posedge clk_sys) disable iff (reset)
    fastStart |=> (fastCnt_q == $past(fastTime_q)))
    else $error("fast timer not loaded");
  chk_fast_outputs: assert property (@(posedge clk_sys) disable iff (reset)
    (fastCnt_q != 13'h0000) |-> loopSwitchClosed && (pumpCurrentCode == fastPumpCode_q)
      || $changed(fastPumpCode_q))
    else $error("fast lock outputs wrong");
  chk_fast_count: assert property (@(posedge clk_sys) disable iff (reset)
    (pfdTick && !fastStart && (fastCnt_q != 13'h0000)) |=>
      (fastCnt_q == $past(fastCnt_q) - 13'h0001))
    else $error("fast timer did not step on reference tick");
  chk_ld_off: assert property (@(posedge clk_sys) disable iff (reset)
    ldOff |=> !lockPin)
    else $error("lock pin high while detection off");
  chk_lock_run: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(lockPin) |-> $past(belowSync_q[1]) && $past(pfdTick)
      && ($past(ldCnt_q) + CNT_W'(1) >= $past(lockTarget_q)))
    else $error("lock declared without run");
  chk_unlock_run: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(lockPin) && !$past(ldOff) |-> $past(aboveSync_q[1]) && $past(pfdTick))
    else $error("unlock declared without bad run");
  chk_sel_rule: assert property (@(posedge clk_sys) disable iff (reset)
    selB == (offsetSelect_q && !$past(transmitPowerdownPin, 2)))
    else $error("offset word selection wrong");
  chk_cnt_restart: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(ldState_q) |-> (ldCnt_q == '0))
    else $error("lock counter not restarted");
  cov_lock: cover property (@(posedge clk_sys) disable iff (reset) $rose(lockPin));
  cov_unlock: cover property (@(posedge clk_sys) disable iff (reset) $fell(lockPin));
  cov_fast_done: cover property (@(posedge clk_sys) disable iff (reset)
    irqEvent[`POFLD_I_FASTDONE]);
  cov_carry: cover property (@(posedge clk_sys) disable iff (reset) recalc && calcCarry);
  cov_to_b: cover property (@(posedge clk_sys) disable iff (reset) !selB_q && selB);
endmodule

// [pofld_host.sv]
/*
  Host model: drives register strobes, the transmit pin and the phase flags.
  Assumes clk_sys times every access and the slave never stalls.
*/
`timescale 1ns/1ps
module pofld_host (
  input wire logic clk_sys,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  output logic transmitPowerdownPin,
  output logic phaseErrBelowRef,
  output logic phaseErrAboveT
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    transmitPowerdownPin = 1'b0;
    phaseErrBelowRef = 1'b0;
    phaseErrAboveT = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one write cycle; unqualified lines are driven to their complements afterwards
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  // one read cycle; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask
  // far side levels: pin, error below one period, error above threshold
  task automatic far(input logic p, input logic b, input logic t);
    @(posedge clk_sys);
    transmitPowerdownPin <= p;
    phaseErrBelowRef <= b;
    phaseErrAboveT <= t;
  endtask
endmodule

// [pofld_top_tb.sv]
/*
  Self-checking bench for the synthesizer control block.
  Assumes the host model drives the register port and far side levels.
*/
`timescale 1ns/1ps
module pofld_top_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  logic regWrEn, regRdEn, transmitPowerdownPin, phaseErrBelowRef, phaseErrAboveT;
  logic sigmaDeltaEnable, loopSwitchClosed, lockPin, irq;
  logic [4:0] pumpCurrentCode;
  logic [5:0] pumpCurrentSteps;
  pofld_pkg::pofld_int_t divIntEff;
  pofld_pkg::pofld_word_t fracNumEff, fracDenominator;
  int nFail = 0;
  int checkCount = 0;
  int cycles = 0;
  always #2 clk_sys = ~clk_sys;
  pofld_top #(.REF_DIV(4), .CNT_W(8)) pofld_top_inst (.clk_sys(clk_sys), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .transmitPowerdownPin(transmitPowerdownPin),
    .phaseErrBelowRef(phaseErrBelowRef), .phaseErrAboveT(phaseErrAboveT),
    .divIntEff(divIntEff), .fracNumEff(fracNumEff), .fracDenominator(fracDenominator),
    .sigmaDeltaEnable(sigmaDeltaEnable), .loopSwitchClosed(loopSwitchClosed),
    .pumpCurrentCode(pumpCurrentCode), .pumpCurrentSteps(pumpCurrentSteps),
    .lockPin(lockPin), .irq(irq));
  pofld_host pofld_host_inst (.clk_sys(clk_sys), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .transmitPowerdownPin(transmitPowerdownPin), .phaseErrBelowRef(phaseErrBelowRef),
    .phaseErrAboveT(phaseErrAboveT));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stopTest();
    if (nFail == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      stopTest();
    end
  end
  task automatic ck(input logic [17:0] got, input logic [17:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    pofld_host_inst.wr(a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tResetState();
    cyc(0);
    ck(18'(lockPin), 18'h0);
    ck(18'(pumpCurrentSteps), 18'h1);
    pofld_host_inst.rd(8'h3F, rdv);
    ck(18'(rdv), 18'h1);
    pofld_host_inst.rd(8'h60, rdv);
    ck(18'(rdv), 18'h0);
  endtask
  task automatic tOffsetA();
    w(8'h03, 8'h10);
    w(8'h05, 8'h01);
    w(8'h08, 8'h64);
    cyc(0);
    ck(fracNumEff, 18'h10);
    ck(18'(divIntEff), 18'h64);
    ck(fracDenominator, 18'h100);
    w(8'h10, 8'h01);
    cyc(0);
    ck(fracNumEff, 18'h10);
    w(8'h10, 8'h00);
    w(8'h11, 8'hF0);
    cyc(0);
    ck(fracNumEff, 18'h0);
    ck(18'(divIntEff), 18'h65);
    w(8'h0F, 8'h03);
    w(8'h10, 8'hFF);
    w(8'h11, 8'hE0);
    cyc(0);
    ck(fracNumEff, 18'hF0);
    ck(18'(divIntEff), 18'h63);
  endtask
  task automatic tOffsetB();
    w(8'h2B, 8'h20);
    cyc(0);
    ck(fracNumEff, 18'hF0);
    w(8'h28, 8'h01);
    cyc(1);
    ck(fracNumEff, 18'h30);
    ck(18'(divIntEff), 18'h64);
    pofld_host_inst.rd(8'h52, rdv);
    ck(18'(rdv), 18'h4);
    w(8'h0F, 8'h00);
    w(8'h10, 8'h00);
    w(8'h11, 8'h05);
    cyc(0);
    ck(fracNumEff, 18'h30);
    pofld_host_inst.far(1'b1, 1'b0, 1'b0);
    cyc(5);
    ck(fracNumEff, 18'h15);
    pofld_host_inst.far(1'b0, 1'b0, 1'b0);
    cyc(5);
    ck(fracNumEff, 18'h30);
    w(8'h28, 8'h00);
    cyc(1);
    ck(fracNumEff, 18'h15);
  endtask
  task automatic tFastLock();
    w(8'h0C, 8'h03);
    cyc(0);
    ck(18'(sigmaDeltaEnable), 18'h1);
    w(8'h0A, 8'h04);
    w(8'h0B, 8'h1F);
    w(8'h0E, 8'h03);
    w(8'h08, 8'h64);
    cyc(0);
    ck(18'(loopSwitchClosed), 18'h1);
    ck(18'(pumpCurrentCode), 18'h1F);
    ck(18'(pumpCurrentSteps), 18'h20);
    cyc(7);
    ck(18'(loopSwitchClosed), 18'h1);
    cyc(8);
    ck(18'(loopSwitchClosed), 18'h0);
    ck(18'(pumpCurrentSteps), 18'h5);
    ck(18'(irq), 18'h0);
    w(8'h51, 8'h04);
    cyc(0);
    ck(18'(irq), 18'h1);
    w(8'h50, 8'h04);
    cyc(0);
    ck(18'(irq), 18'h0);
  endtask
  task automatic tLockDetect();
    w(8'h3F, 8'h03);
    w(8'h40, 8'h02);
    pofld_host_inst.far(1'b0, 1'b1, 1'b0);
    cyc(8);
    ck(18'(lockPin), 18'h0);
    cyc(12);
    ck(18'(lockPin), 18'h1);
    pofld_host_inst.rd(8'h50, rdv);
    ck(18'(rdv[0]), 18'h1);
    pofld_host_inst.far(1'b0, 1'b0, 1'b1);
    cyc(4);
    ck(18'(lockPin), 18'h1);
    cyc(12);
    ck(18'(lockPin), 18'h0);
    pofld_host_inst.far(1'b0, 1'b1, 1'b0);
    w(8'h0C, 8'h07);
    cyc(24);
    ck(18'(lockPin), 18'h0);
    w(8'h0C, 8'h03);
    cyc(24);
    ck(18'(lockPin), 18'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    tResetState();
    tOffsetA();
    tOffsetB();
    tFastLock();
    tLockDetect();
    stopTest();
  end
endmodule
